// ==== asc_defs.vh ====
`ifndef ASC_DEFS_VH
`define ASC_DEFS_VH

// register block placement on the 16-bit peripheral bus (word addresses)
`define ASC_BASE 16'h7050
`define ASC_BASE_HI 12'h705
`define ASC_NREGS 4'hB

// register indices, added to the base
`define ASC_REG_FMT 4'h0
`define ASC_REG_CTL 4'h1
`define ASC_REG_BAUD_HI 4'h2
`define ASC_REG_BAUD_LO 4'h3
`define ASC_REG_INTC 4'h4
`define ASC_REG_RXST 4'h5
`define ASC_REG_RXPEEK 4'h6
`define ASC_REG_RXDAT 4'h7
`define ASC_REG_TXPIN 4'h8
`define ASC_REG_TXDAT 4'h9
`define ASC_REG_RXPIN 4'hA

// frame format register fields
`define ASC_FMT_LEN_HI 2
`define ASC_FMT_ADDR 3
`define ASC_FMT_PEN 4
`define ASC_FMT_PEVEN 5
`define ASC_FMT_STOP2 6

// main control register fields
`define ASC_CTL_TXEN 0
`define ASC_CTL_RXEN 1
`define ASC_CTL_SLEEP 2
`define ASC_CTL_TXWAKE 3
`define ASC_CTL_ERRIE 4

// interrupt control / transmit status fields
`define ASC_INTC_TXIE 0
`define ASC_INTC_RXIE 1
`define ASC_INTC_TXEMPTY 6
`define ASC_INTC_TX_BUFFER_READY 7

// receive status fields
`define ASC_RXST_WAKE 0
`define ASC_RXST_PE 1
`define ASC_RXST_OE 2
`define ASC_RXST_FE 3
`define ASC_RXST_BRK 4
`define ASC_RXST_FULL 5
`define ASC_RXST_ERR 6

// pin control fields
`define ASC_PIN_FUNC 0
`define ASC_PIN_DIR 1
`define ASC_PIN_DOUT 2
`define ASC_PIN_DIN 3

// reset values
`define ASC_FMT_RST 8'h07
`define ASC_CTL_RST 8'h00
`define ASC_BAUD_RST 16'h0000
`define ASC_INTC_RST 2'h0
`define ASC_PIN_RST 3'h0

// timing: bit cell in baud ticks, centre sample, idle gap, wake gap
`define ASC_TICKS_PER_BIT 16
`define ASC_TICK_LAST 4'hF
`define ASC_TICK_MID 4'h7
`define ASC_IDLE_BITS 10
`define ASC_WAKE_IDLE_BITS 11

`endif

// ==== asc_tx.v ====
`timescale 1ns/1ps
`include "asc_defs.vh"

module asc_tx #(
  parameter FRAME_W = 24
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire tick,
  input wire tx_enable,
  input wire load,
  input wire [7:0] load_data,
  input wire [2:0] char_len,
  input wire addr_mode,
  input wire par_en,
  input wire par_even,
  input wire two_stop,
  input wire wake,
  output wire wake_taken,
  output wire tx_line,
  output wire tx_buffer_ready,
  output wire tx_empty
);

reg [7:0] hold;
reg hold_full;
reg [FRAME_W-1:0] shifter;
reg [4:0] bits_left;
reg [3:0] tick_cnt;
reg [FRAME_W-1:0] vec;
reg [4:0] next_count;
reg par;
integer n;
integer i;
wire start;

////////////////////////////////////////////////////////////////////////
// frame image: optional idle gap, start, data lsb first, addr, parity
always @*
begin
  vec = {FRAME_W{1'b1}};
  par = 1'b0;
  n = 0;
  if (!addr_mode && wake)
    n = `ASC_WAKE_IDLE_BITS;
  vec[n] = 1'b0;
  n = n + 1;
  for (i = 0; i < 8; i = i + 1)
  begin
    if (i <= char_len)
    begin
      vec[n] = hold[i];
      par = par ^ hold[i];
      n = n + 1;
    end
  end
  if (addr_mode)
  begin
    vec[n] = wake;
    par = par ^ wake;
    n = n + 1;
  end
  if (par_en)
  begin
    vec[n] = par_even ? par : ~par;
    n = n + 1;
  end
  // stop bits are already ones in the image
  next_count = n[4:0] + 5'd1 + {4'd0, two_stop};
end

// a frame starts as soon as the shifter is idle and a character waits
assign start = tx_enable && hold_full && (bits_left == 5'd0);

////////////////////////////////////////////////////////////////////////
// holding buffer and shifter; a load in the start cycle is kept
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    hold <= 8'h00;
    hold_full <= 1'b0;
    shifter <= {FRAME_W{1'b1}};
    bits_left <= 5'd0;
    tick_cnt <= 4'h0;
  end
  else if (ce)
  begin
    if (start)
    begin
      shifter <= vec;
      bits_left <= next_count;
      tick_cnt <= 4'h0;
      hold_full <= 1'b0;
    end
    else if (bits_left != 5'd0 && tick)
    begin
      if (tick_cnt == `ASC_TICK_LAST)
      begin
        shifter <= {1'b1, shifter[FRAME_W-1:1]};
        bits_left <= bits_left - 5'd1;
        tick_cnt <= 4'h0;
      end
      else
        tick_cnt <= tick_cnt + 4'h1;
    end
    if (load)
    begin
      hold <= load_data;
      hold_full <= 1'b1;
    end
  end
end

// the line is the shifter's low bit: ones fill it, so idle is mark
assign tx_line = shifter[0];
assign wake_taken = ce && start && wake;
assign tx_buffer_ready = !hold_full;
assign tx_empty = !hold_full && (bits_left == 5'd0);

endmodule // asc_tx

// ==== asc_core.v ====
// How it works
// - transmit and receive each have holding buffer, enable and interrupt
// - transmitter and receiver run alone or together, half or full duplex
// - receiver flags break, parity, overrun and framing errors separately
// - bit rate comes from a 16-bit divisor in two baud registers
// - fastest rate is system clock over sixteen, 625 kbit/s at 10 MHz
// - frame has one start bit then one to eight data bits
// - optional parity bit after data, even or odd
// - frame ends with one or two stop bits
// - wake-up by idle-line gap or by address bit
// - transmit-ready flag while the holding buffer can take a character
// - transmitter-empty flag when nothing is left to send
// - receive-full flag while a character waits for software
// - break-detected flag when a break arrives on the receive line
// - combined receive-error flag when any of the four errors is set
// - separate tx and rx interrupt enables; break ignores those enables
// - eleven registers decoded from base 7050h
// - eight-bit registers on bits 7..0, upper byte reads zero
// - both pins use non-return-to-zero coding
// - each pin serves the serial link or works as general purpose i/o
// - all status flags are readable for polling or interrupt service
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "asc_defs.vh"

module asc_core #(
  parameter ADDR_W = 16
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [ADDR_W-1:0] bus_addr,
  input wire [15:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [15:0] bus_rdata,
  input wire serial_tx_pin_in,
  output wire serial_tx_pin_out,
  output wire serial_tx_pin_oe,
  input wire serial_rx_pin_in,
  output wire serial_rx_pin_out,
  output wire serial_rx_pin_oe,
  output wire tx_int,
  output wire rx_int,
  output wire tx_buffer_ready,
  output wire rx_buffer_full,
  output wire break_detected
);

localparam [3:0] S_IDLE = 4'b0001;
localparam [3:0] S_START = 4'b0010;
localparam [3:0] S_DATA = 4'b0100;
localparam [3:0] S_STOP = 4'b1000;
localparam [31:0] IDLE_PROD = `ASC_IDLE_BITS * `ASC_TICKS_PER_BIT;
localparam [7:0] IDLE_TICKS = IDLE_PROD[7:0];

reg [7:0] fmt;
reg [7:0] ctl;
reg [15:0] baud;
reg [1:0] intc;
reg [2:0] txpin;
reg [2:0] rxpin;
reg [15:0] baud_cnt;
reg rx_s1;
reg rx_s2;
reg txp_s1;
reg txp_s2;
reg rx_prev;
reg [3:0] rx_state;
reg [3:0] rx_tcnt;
reg [3:0] rx_bitn;
reg [9:0] rx_shift;
reg [7:0] idle_cnt;
reg idle_seen;
reg frame_addr;
reg [7:0] rx_data;
reg rx_full;
reg rx_wake;
reg err_par;
reg err_ovr;
reg err_frm;
reg err_brk;
reg [9:0] aligned;
reg [7:0] fr_data;
reg fr_addr;
reg fr_par_ok;
reg [7:0] rd_mux;
integer k;

wire hit;
wire [3:0] idx;
wire wr;
wire rd;
wire tick;
wire rx_line;
wire [3:0] rx_nb;
wire rx_finish;
wire fr_is_addr;
wire fr_accept;
wire fr_break;
wire rx_error;
wire rxdat_read;
wire rxst_write;
wire wake_taken;
wire tx_line;
wire tx_empty;

////////////////////////////////////////////////////////////////////////
// address decode: eleven word registers from the base upward
assign hit = (bus_addr[ADDR_W-1:4] == `ASC_BASE_HI) &&
             (bus_addr[3:0] < `ASC_NREGS);
assign idx = bus_addr[3:0];
assign wr = ce && bus_wr && hit;
assign rd = ce && bus_rd && hit;
assign rxdat_read = rd && (idx == `ASC_REG_RXDAT);
assign rxst_write = wr && (idx == `ASC_REG_RXST);

// control registers; only the low byte is stored, upper byte dropped
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    fmt <= `ASC_FMT_RST;
    ctl <= `ASC_CTL_RST;
    baud <= `ASC_BAUD_RST;
    intc <= `ASC_INTC_RST;
    txpin <= `ASC_PIN_RST;
    rxpin <= `ASC_PIN_RST;
  end
  else if (ce)
  begin
    // hardware clears the wake request once the frame carrying it starts
    if (wake_taken)
      ctl[`ASC_CTL_TXWAKE] <= 1'b0;
    if (wr)
    begin
      case (idx)
        `ASC_REG_FMT: fmt <= bus_wdata[7:0];
        `ASC_REG_CTL: ctl <= bus_wdata[7:0];
        `ASC_REG_BAUD_HI: baud[15:8] <= bus_wdata[7:0];
        `ASC_REG_BAUD_LO: baud[7:0] <= bus_wdata[7:0];
        `ASC_REG_INTC: intc <= bus_wdata[1:0];
        `ASC_REG_TXPIN: txpin <= bus_wdata[2:0];
        `ASC_REG_RXPIN: rxpin <= bus_wdata[2:0];
        default: ;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////
// baud tick: one tick every divisor+1 clocks, sixteen ticks a bit, so
// divisor zero gives clk/16 (625 kbit/s from a 10 MHz clock)
always @(posedge clk or posedge rst)
begin
  if (rst)
    baud_cnt <= 16'h0000;
  else if (ce)
  begin
    if (baud_cnt == 16'h0000)
      baud_cnt <= baud;
    else
      baud_cnt <= baud_cnt - 16'h0001;
  end
end

assign tick = (baud_cnt == 16'h0000);

////////////////////////////////////////////////////////////////////////
// pin synchronisers; the first stage feeds only the second
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    rx_s1 <= 1'b1;
    rx_s2 <= 1'b1;
    txp_s1 <= 1'b1;
    txp_s2 <= 1'b1;
  end
  else if (ce)
  begin
    rx_s1 <= serial_rx_pin_in;
    rx_s2 <= rx_s1;
    txp_s1 <= serial_tx_pin_in;
    txp_s2 <= txp_s1;
  end
end

// a pin given to general i/o shows the receiver a resting mark
assign rx_line = rxpin[`ASC_PIN_FUNC] ? rx_s2 : 1'b1;

////////////////////////////////////////////////////////////////////////
// transmitter
asc_tx #(
  .FRAME_W(24)
) u_tx (
  .clk(clk),
  .rst(rst),
  .ce(ce),
  .tick(tick),
  .tx_enable(ctl[`ASC_CTL_TXEN]),
  .load(wr && (idx == `ASC_REG_TXDAT)),
  .load_data(bus_wdata[7:0]),
  .char_len(fmt[`ASC_FMT_LEN_HI:0]),
  .addr_mode(fmt[`ASC_FMT_ADDR]),
  .par_en(fmt[`ASC_FMT_PEN]),
  .par_even(fmt[`ASC_FMT_PEVEN]),
  .two_stop(fmt[`ASC_FMT_STOP2]),
  .wake(ctl[`ASC_CTL_TXWAKE]),
  .wake_taken(wake_taken),
  .tx_line(tx_line),
  .tx_buffer_ready(tx_buffer_ready),
  .tx_empty(tx_empty)
);

////////////////////////////////////////////////////////////////////////
// receiver bit count: data bits, then address bit and parity if used
assign rx_nb = {1'b0, fmt[`ASC_FMT_LEN_HI:0]} + 4'd1 +
               {3'd0, fmt[`ASC_FMT_ADDR]} + {3'd0, fmt[`ASC_FMT_PEN]};
assign rx_finish = (rx_state == S_STOP) && tick &&
                   (rx_tcnt == `ASC_TICK_LAST);

// receive sequencer; a false start (line high at mid cell) is dropped
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    rx_state <= S_IDLE;
    rx_tcnt <= 4'h0;
    rx_bitn <= 4'h0;
    rx_shift <= 10'h000;
    rx_prev <= 1'b1;
    idle_cnt <= 8'h00;
    idle_seen <= 1'b0;
    frame_addr <= 1'b0;
  end
  else if (ce)
  begin
    rx_prev <= rx_line;
    if (!ctl[`ASC_CTL_RXEN])
    begin
      rx_state <= S_IDLE;
      idle_cnt <= 8'h00;
      idle_seen <= 1'b0;
    end
    else
    begin
      case (rx_state)
        S_IDLE:
        begin
          if (rx_prev && !rx_line)
          begin
            rx_state <= S_START;
            rx_tcnt <= 4'h0;
            frame_addr <= idle_seen;
            idle_seen <= 1'b0;
            idle_cnt <= 8'h00;
          end
          else if (tick)
          begin
            // a gap of ten mark bits marks the next frame as an address
            if (!rx_line)
              idle_cnt <= 8'h00;
            else if (idle_cnt >= IDLE_TICKS - 8'd1)
              idle_seen <= 1'b1;
            else
              idle_cnt <= idle_cnt + 8'h01;
          end
        end
        S_START:
        begin
          if (tick)
          begin
            if (rx_tcnt == `ASC_TICK_MID)
            begin
              rx_tcnt <= 4'h0;
              rx_bitn <= 4'h0;
              rx_state <= rx_line ? S_IDLE : S_DATA;
            end
            else
              rx_tcnt <= rx_tcnt + 4'h1;
          end
        end
        S_DATA:
        begin
          if (tick)
          begin
            if (rx_tcnt == `ASC_TICK_LAST)
            begin
              // mid-cell sample, shifted in from the top, lsb first
              rx_shift <= {rx_line, rx_shift[9:1]};
              rx_tcnt <= 4'h0;
              rx_bitn <= rx_bitn + 4'h1;
              if (rx_bitn == rx_nb - 4'd1)
                rx_state <= S_STOP;
            end
            else
              rx_tcnt <= rx_tcnt + 4'h1;
          end
        end
        S_STOP:
        begin
          // only the first stop bit is checked, so two-stop frames
          // may be followed at once by the next start edge
          if (rx_finish)
            rx_state <= S_IDLE;
          else if (tick)
            rx_tcnt <= rx_tcnt + 4'h1;
        end
        default: rx_state <= S_IDLE;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////
// unpack the frame: align, then pick data, address bit and parity
always @*
begin
  aligned = rx_shift >> (4'd10 - rx_nb);
  fr_data = 8'h00;
  for (k = 0; k < 8; k = k + 1)
  begin
    if (k <= fmt[`ASC_FMT_LEN_HI:0])
      fr_data[k] = aligned[k];
  end
  fr_addr = fmt[`ASC_FMT_ADDR] ? aligned[fmt[`ASC_FMT_LEN_HI:0] + 4'd1] :
            1'b0;
  // even parity: all counted bits xor to zero; odd: to one
  fr_par_ok = ((^(aligned & ((10'h001 << rx_nb) - 10'h001))) ==
              !fmt[`ASC_FMT_PEVEN]);
end

assign fr_is_addr = fmt[`ASC_FMT_ADDR] ? fr_addr : frame_addr;
assign fr_accept = !ctl[`ASC_CTL_SLEEP] || fr_is_addr;
assign fr_break = (aligned == 10'h000) && !rx_line;

////////////////////////////////////////////////////////////////////////
// receive buffer and status; a new event wins over a same-cycle clear
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    rx_data <= 8'h00;
    rx_full <= 1'b0;
    rx_wake <= 1'b0;
    err_par <= 1'b0;
    err_ovr <= 1'b0;
    err_frm <= 1'b0;
    err_brk <= 1'b0;
  end
  else if (ce)
  begin
    if (rxdat_read)
      rx_full <= 1'b0;
    if (rxst_write)
    begin
      // write one to clear the error flags
      if (bus_wdata[`ASC_RXST_PE])
        err_par <= 1'b0;
      if (bus_wdata[`ASC_RXST_OE])
        err_ovr <= 1'b0;
      if (bus_wdata[`ASC_RXST_FE])
        err_frm <= 1'b0;
      if (bus_wdata[`ASC_RXST_BRK])
        err_brk <= 1'b0;
    end
    if (rx_finish && ctl[`ASC_CTL_RXEN])
    begin
      if (fr_break)
        err_brk <= 1'b1;
      if (fr_accept)
      begin
        rx_data <= fr_data;
        rx_wake <= fr_is_addr;
        rx_full <= 1'b1;
        if (rx_full && !rxdat_read)
          err_ovr <= 1'b1;
        if (fmt[`ASC_FMT_PEN] && !fr_par_ok)
          err_par <= 1'b1;
        if (!rx_line)
          err_frm <= 1'b1;
      end
    end
  end
end

assign rx_error = err_par | err_ovr | err_frm | err_brk;

////////////////////////////////////////////////////////////////////////
// read mux; unmapped and reserved bits read zero
always @*
begin
  case (idx)
    `ASC_REG_FMT: rd_mux = fmt;
    `ASC_REG_CTL: rd_mux = ctl;
    `ASC_REG_BAUD_HI: rd_mux = baud[15:8];
    `ASC_REG_BAUD_LO: rd_mux = baud[7:0];
    `ASC_REG_INTC: rd_mux = {tx_buffer_ready, tx_empty, 4'h0, intc};
    `ASC_REG_RXST: rd_mux = {1'b0, rx_error, rx_full, err_brk, err_frm,
                             err_ovr, err_par, rx_wake};
    `ASC_REG_RXPEEK: rd_mux = rx_data;
    `ASC_REG_RXDAT: rd_mux = rx_data;
    `ASC_REG_TXPIN: rd_mux = {4'h0, txp_s2, txpin};
    `ASC_REG_RXPIN: rd_mux = {4'h0, rx_s2, rxpin};
    default: rd_mux = 8'h00;
  endcase
end

// read data stands only in the cycle after the strobe
always @(posedge clk or posedge rst)
begin
  if (rst)
    bus_rdata <= 16'h0000;
  else if (ce)
  begin
    if (rd)
      bus_rdata <= {8'h00, rd_mux};
    else
      bus_rdata <= 16'h0000;
  end
end

////////////////////////////////////////////////////////////////////////
// pins: serial function or plain i/o driven by direction bit
assign serial_tx_pin_out = txpin[`ASC_PIN_FUNC] ? tx_line :
                           txpin[`ASC_PIN_DOUT];
assign serial_tx_pin_oe = txpin[`ASC_PIN_FUNC] | txpin[`ASC_PIN_DIR];
assign serial_rx_pin_out = rxpin[`ASC_PIN_DOUT];
assign serial_rx_pin_oe = !rxpin[`ASC_PIN_FUNC] &&
                          rxpin[`ASC_PIN_DIR];

// interrupt requests; break is not held back by the tx/rx enables
assign tx_int = intc[`ASC_INTC_TXIE] && tx_buffer_ready;
assign rx_int = (intc[`ASC_INTC_RXIE] && rx_full) ||
                (ctl[`ASC_CTL_ERRIE] && rx_error) || err_brk;

assign rx_buffer_full = rx_full;
assign break_detected = err_brk;

endmodule // asc_core

// ==== asc_core_sva.sv ====
`timescale 1ns/1ps
module asc_core_sva #(
  parameter ADDR_W = 16
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [ADDR_W-1:0] bus_addr,
  input wire [15:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  input wire [15:0] bus_rdata,
  input wire serial_tx_pin_in,
  input wire serial_tx_pin_out,
  input wire serial_tx_pin_oe,
  input wire serial_rx_pin_in,
  input wire serial_rx_pin_out,
  input wire serial_rx_pin_oe,
  input wire tx_int,
  input wire rx_int,
  input wire tx_buffer_ready,
  input wire rx_buffer_full,
  input wire break_detected
);
  ////////////////////////////////////////
  // one clock domain, everything stops checking while reset is high
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // bus steps that the properties hang on
  sequence s_txdat_wr;
    ce && bus_wr && bus_addr == 16'h7059;
  endsequence
  sequence s_stat_rd;
    ce && bus_rd && bus_addr == 16'h7055;
  endsequence
  // read data only in the cycle after a read, upper byte always zero
  property p_rd_gap;
    ce && !bus_rd |=> bus_rdata == 16'h0000;
  endproperty
  property p_upper;
    bus_rdata[15:8] == 8'h00;
  endproperty
  property p_unmap;
    ce && bus_rd && (bus_addr < 16'h7050 || bus_addr > 16'h705A)
      |=> bus_rdata == 16'h0000;
  endproperty
  // status read returns the flags as they stood at the read edge
  property p_stat;
    s_stat_rd |=> bus_rdata[5:4] == $past({rx_buffer_full, break_detected});
  endproperty
  // holding buffer fills only from a data write
  property p_tx_load;
    s_txdat_wr |=> !tx_buffer_ready;
  endproperty
  property p_ready_fall;
    $fell(tx_buffer_ready) |-> $past(ce && bus_wr && bus_addr == 16'h7059);
  endproperty
  // full flag drops only by reading the data register
  property p_full_fall;
    $fell(rx_buffer_full) |-> $past(ce && bus_rd && bus_addr == 16'h7057);
  endproperty
  // break stays until software writes one to its status bit
  property p_brk_hold;
    break_detected && !(bus_wr && bus_addr == 16'h7055 && bus_wdata[4])
      |=> break_detected;
  endproperty
  // break reaches the interrupt even with every enable off
  property p_brk_int;
    break_detected |-> rx_int;
  endproperty
  property p_tx_int;
    tx_int |-> tx_buffer_ready;
  endproperty
  a_rd_gap: assert property (p_rd_gap)
    else $error("read data outside the answer cycle");
  a_upper: assert property (p_upper)
    else $error("upper read byte not zero");
  a_unmap: assert property (p_unmap)
    else $error("unmapped read gave data");
  a_stat: assert property (p_stat)
    else $error("status read differs from flags");
  a_tx_load: assert property (p_tx_load)
    else $error("data write left tx buffer ready");
  a_ready_fall: assert property (p_ready_fall)
    else $error("tx ready fell without a data write");
  a_full_fall: assert property (p_full_fall)
    else $error("rx full fell without a data read");
  a_brk_hold: assert property (p_brk_hold)
    else $error("break flag lost without clear");
  a_brk_int: assert property (p_brk_int)
    else $error("break without rx interrupt");
  a_tx_int: assert property (p_tx_int)
    else $error("tx interrupt while buffer busy");
endmodule // asc_core_sva

bind asc_core asc_core_sva #(.ADDR_W(ADDR_W)) i_asc_core_sva (
  .clk(clk), .rst(rst), .ce(ce), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .serial_tx_pin_in(serial_tx_pin_in),
  .serial_tx_pin_out(serial_tx_pin_out), .serial_tx_pin_oe(serial_tx_pin_oe),
  .serial_rx_pin_in(serial_rx_pin_in), .serial_rx_pin_out(serial_rx_pin_out),
  .serial_rx_pin_oe(serial_rx_pin_oe), .tx_int(tx_int), .rx_int(rx_int),
  .tx_buffer_ready(tx_buffer_ready), .rx_buffer_full(rx_buffer_full),
  .break_detected(break_detected)
);

// ==== asc_peer.sv ====
`timescale 1ns/1ps
module asc_peer #(
  parameter int BT = 32
) (
  input wire clk,
  input wire tx_line,
  output logic rx_line
);
  ////////////////////////////////////////
  // line rests at mark between frames
  initial rx_line = 1'b1;
  // start bit, then n frame bits lsb first, nrz, back to mark
  task automatic send(input logic [15:0] v, input int n);
    @(posedge clk);
    rx_line <= 1'b0;
    repeat (BT) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      rx_line <= v[i];
      repeat (BT) @(posedge clk);
    end
    rx_line <= 1'b1;
  endtask
  // returns at the centre of the last cell so a next start is not missed
  task automatic get(input int n, output logic [15:0] v);
    v = 16'h0000;
    @(negedge tx_line);
    for (int i = 0; i < n; i++)
    begin
      repeat (i == 0 ? BT / 2 : BT) @(posedge clk);
      v[i] = tx_line;
    end
  endtask
endmodule // asc_peer

// ==== asc_core_test.sv ====
`timescale 1ns/1ps
module asc_core_test;
  localparam int BT = 32; // divisor 1: 16 ticks of 2 clocks per bit
  localparam logic [15:0] B = 16'h7050;
  logic clk, rst, ce, bus_wr, bus_rd;
  logic [15:0] bus_addr, bus_wdata, v, got, g2;
  wire [15:0] bus_rdata;
  wire tx_o, tx_oe, rx_o, rx_oe, tx_int, rx_int, txr, rxf, brk, peer_line;
  wire tx_w = tx_oe ? tx_o : 1'b1; // pull-up on the released tx wire
  wire rx_w = rx_oe ? rx_o : peer_line;
  int error_cnt, n_tests, n;
  time t0;
  logic [7:0] fm[4] = '{8'h07, 8'h36, 8'h54, 8'h00};
  logic [7:0] dt[4] = '{8'hA5, 8'h5A, 8'h13, 8'h01};
  logic [15:0] fl[3] = '{16'h0100, 16'h0200, 16'h0000};
  logic [15:0] ex[3] = '{16'h0062, 16'h0068, 16'h0064};
  ////////////////////////////////////////
  asc_core i_asc_core (
    .clk(clk), .rst(rst), .ce(ce), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .serial_tx_pin_in(tx_w),
    .serial_tx_pin_out(tx_o), .serial_tx_pin_oe(tx_oe),
    .serial_rx_pin_in(rx_w), .serial_rx_pin_out(rx_o),
    .serial_rx_pin_oe(rx_oe), .tx_int(tx_int), .rx_int(rx_int),
    .tx_buffer_ready(txr), .rx_buffer_full(rxf), .break_detected(brk)
  );
  asc_peer #(.BT(BT)) i_asc_peer (
    .clk(clk), .tx_line(tx_w), .rx_line(peer_line)
  );
  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] s, e, input string nm);
    n_tests++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= B + a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  // data stands only in the cycle after the read edge
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= B + a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask
  task automatic rc(input logic [3:0] a, logic [15:0] e, string nm);
    logic [15:0] d;
    rd(a, d);
    chk(d, e, nm);
  endtask
  // bounded wait, sampled on the falling edge where flags are settled
  task automatic wait_full();
    for (int i = 0; i < 4000 && rxf !== 1'b1; i++)
      @(negedge clk);
    chk(rxf, 1'b1, "rx_full");
  endtask
  // frame bits after the start bit, format register layout
  function automatic logic [15:0] mk(input logic [7:0] d, logic [7:0] f,
      logic ab, output int n);
    logic q[$];
    logic p;
    logic [15:0] r;
    p = ^(d & (8'hFF >> (3'd7 - f[2:0]))) ^ (ab & f[3]);
    for (int i = 0; i <= f[2:0]; i++)
      q.push_back(d[i]);
    if (f[3])
      q.push_back(ab);
    if (f[4])
      q.push_back(p ^ ~f[5]);
    q.push_back(1'b1);
    if (f[6])
      q.push_back(1'b1);
    r = 16'h0000;
    foreach (q[i])
      r[i] = q[i];
    n = q.size();
    return r;
  endfunction
  task automatic test_done();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // hang guard, about seven times the expected run
  initial
  begin
    #200_000;
    error_cnt++;
    test_done();
  end
  ////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 16'h0000;
    bus_wdata = 16'h0000;
    error_cnt = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // reset values, bus edges, divisor halves
    rc(4'h0, 16'h0007, "fmt");
    rc(4'h4, 16'h00C0, "intc");
    rc(4'h5, 16'h0000, "rxst");
    rc(4'hB, 16'h0000, "unmapped");
    wr(4'h2, 16'hAB00);
    rc(4'h2, 16'h0000, "baud_hi");
    wr(4'h3, 16'h0001);
    rc(4'h3, 16'h0001, "baud_lo");
    // tx pin as general purpose output, driven low
    wr(4'h8, 16'h0002);
    repeat (4) @(posedge clk);
    rc(4'h8, 16'h0002, "tx_gpio");
    wr(4'h8, 16'h0001);
    // rx pin as general purpose output, driven high
    wr(4'hA, 16'h0006);
    #1 chk({rx_oe, rx_o}, 2'b11, "rx_gpio");
    wr(4'hA, 16'h0001);
    wr(4'h1, 16'h0003);
    // lengths 8, 7, 5 and 1, no, even and odd parity, one and two stops, both directions
    for (int k = 0; k < 4; k++)
    begin
      wr(4'h0, {8'h00, fm[k]});
      v = mk(dt[k], fm[k], 1'b0, n);
      fork
        i_asc_peer.get(n + 1, got);
        wr(4'h9, {8'h00, dt[k]});
      join
      chk(got, {v[14:0], 1'b0}, "tx_frame");
      repeat (BT) @(posedge clk);
      rc(4'h4, 16'h00C0, "tx_empty");
      i_asc_peer.send(v, n);
      wait_full();
      rc(4'h6, {8'h00, dt[k]}, "rx_peek");
      rc(4'h7, {8'h00, dt[k]}, "rx_data");
      rd(4'h5, got);
      chk(got & 16'h007E, 16'h0000, "rx_clean");
    end
    // two chars queued while a char arrives
    wr(4'h0, 16'h0007);
    v = mk(8'hC3, 8'h07, 1'b0, n);
    fork
      i_asc_peer.send(v, n);
      begin
        i_asc_peer.get(10, got);
        i_asc_peer.get(10, g2);
      end
      begin
        wr(4'h9, 16'h0031);
        wr(4'h9, 16'h0032);
        #1 chk(txr, 1'b0, "tx_ready");
      end
    join
    chk(got, 16'h0262, "tx_first");
    chk(g2, 16'h0264, "tx_second");
    wait_full();
    chk(rx_int, 1'b0, "rx_int_masked");
    wr(4'h4, 16'h0003);
    #1 chk({rx_int, tx_int}, 2'b11, "ints_on");
    rc(4'h7, 16'h00C3, "duplex_rx");
    wr(4'h4, 16'h0000);
    #1 chk({rx_int, tx_int}, 2'b00, "ints_off");
    // parity, framing and overrun, then one-to-clear
    wr(4'h0, 16'h0037);
    for (int k = 0; k < 3; k++)
    begin
      v = mk(8'h5C, 8'h37, 1'b0, n) ^ fl[k];
      i_asc_peer.send(v, n);
      if (k == 2)
        i_asc_peer.send(v, n);
      wait_full();
      rd(4'h5, got);
      chk(got & 16'h007E, ex[k], "rx_error");
      rd(4'h7, got);
      wr(4'h5, 16'h001E);
      rd(4'h5, got);
      chk(got & 16'h007E, 16'h0000, "err_clear");
    end
    // long space: break, ungated interrupt
    i_asc_peer.send(16'h0000, 12);
    repeat (2 * BT) @(negedge clk);
    chk({brk, rx_int}, 2'b11, "break");
    rd(4'h5, got);
    chk(got & 16'h0010, 16'h0010, "brk_status");
    rd(4'h7, got);
    wr(4'h5, 16'h001E);
    #1 chk(brk, 1'b0, "brk_clear");
    // address-bit wake: plain char dropped, address char taken
    wr(4'h0, 16'h000F);
    wr(4'h1, 16'h0007);
    v = mk(8'h11, 8'h0F, 1'b0, n);
    i_asc_peer.send(v, n);
    repeat (2 * BT) @(negedge clk);
    chk(rxf, 1'b0, "sleep_drop");
    v = mk(8'h22, 8'h0F, 1'b1, n);
    i_asc_peer.send(v, n);
    wait_full();
    rd(4'h5, got);
    chk(got & 16'h0001, 16'h0001, "wake_flag");
    rc(4'h7, 16'h0022, "addr_data");
    // divisor 0: idle gap, then start and eight zeros of 16 clocks each
    wr(4'h0, 16'h0007);
    wr(4'h3, 16'h0000);
    wr(4'h1, 16'h000B);
    fork
      wr(4'h9, 16'h0000);
      begin
        @(negedge tx_w);
        t0 = $time;
        @(posedge tx_w);
        chk(16'($time - t0), 16'd720, "fast_rate");
      end
    join
    rc(4'h1, 16'h0003, "txwake_clear");
    test_done();
  end
endmodule // asc_core_test
